// File: rtl/pssc_params.svh
// Constants of the phase, sync and stack command registers
// How it works
// - Broadcast selector reads per-phase fault flag word
// - Single phase selector reads that phase's faults
// - Unused phase bits always read zero
// - Flags in bits 3:0, upper bits zero
// - Direction field: off, out, in, auto
// - Edge bit: zero falling, one rising
// - Invalid sync or stack data flagged
// - Auto mode picks direction at enable
// - Follower uses input, faults without sync
// - Lower limit frequency held until disable
// - Sync fault then output: oscillator at 70%
// - Stack size writable only while disabled
// - Stack upper bits and address read zero
// - Stack codes 0 to 3 valid only
// - Standalone power-up keeps backchannel off
// - Multiphase power-up allows live size changes
`ifndef PSSC_PARAMS_SVH
`define PSSC_PARAMS_SVH
// ----------------------------------------
// Command codes and selectors
// ----------------------------------------
`define PSSC_CMD_PHASE_SUM 8'hDC
`define PSSC_CMD_SYNC_CFG 8'hE4
`define PSSC_CMD_STACK_CFG 8'hEC
`define PSSC_PHASE_ALL 8'hFF
`define PSSC_PHASE_ALT 8'h80
// ----------------------------------------
// Field values
// ----------------------------------------
`define PSSC_SYNC_LOW_FIX 5'h10
`define PSSC_STACK_ALONE 4'h0
`define PSSC_STACK_MAX 4'h3
`define PSSC_BC_FIRST_ADDR 4'h0
`define PSSC_FLAG_PAD 12'h000
`define PSSC_STACK_PAD 8'h00
`define PSSC_BYTE_PAD 8'h00
// ----------------------------------------
// Sync presence timing, in quarter switching periods
// ----------------------------------------
// 75 percent of fsw is a period of 5.33 quarters; 5 is the last legal gap
`define PSSC_GAP_MAX 3'h5
`define PSSC_GAP_SAT 3'h6
`define PSSC_GAP_ONE 3'h1
`define PSSC_GAP_ZERO 3'h0
`endif

// File: rtl/pssc_pkg.sv
// Types shared by the phase, sync and stack command logic
package pssc_pkg;
    // Sync direction field encodings
    typedef enum logic [1:0] {
        PSSC_DIR_OFF = 2'h0,
        PSSC_DIR_OUT = 2'h1,
        PSSC_DIR_IN = 2'h2,
        PSSC_DIR_AUTO = 2'h3
    } pssc_dir_e;
    // Oscillator control states, one-hot
    typedef enum logic [2:0] {
        PSSC_OSC_IDLE = 3'h1,
        PSSC_OSC_RUN = 3'h2,
        PSSC_OSC_HOLD = 3'h4
    } pssc_osc_e;
    typedef logic [3:0] pssc_flags_t;
endpackage

// File: rtl/pssc_cfg_if.sv
// Signals between the command logic and its two helpers
`timescale 1ns/1ps
interface pssc_cfg_if;
    import pssc_pkg::*;
    pssc_dir_e sync_dir; // Configured direction
    logic sync_edge; // Edge select bit
    logic conv_en; // Conversion enable
    logic is_follower; // Device is a loop follower
    logic [7:0] phase_sel; // Phase selector
    pssc_flags_t clr_mask; // Flags to clear
    logic [15:0] sum_word; // Fault summary read word
    modport top (output sync_dir, sync_edge, conv_en, is_follower,
                 phase_sel, clr_mask, input sum_word);
    modport sync (input sync_dir, sync_edge, conv_en, is_follower);
    modport fault (input phase_sel, clr_mask, output sum_word);
endinterface

// File: rtl/pssc_fault_map.sv
// Sticky per-phase fault flags and the summary read word
`timescale 1ns/1ps
`include "pssc_params.svh"
module pssc_fault_map (
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire pssc_pkg::pssc_flags_t phase_fault,
    input wire pssc_pkg::pssc_flags_t phase_used,
    pssc_cfg_if.fault cfg
);
    import pssc_pkg::*;
    // ----------------------------------------
    // Flag storage
    // ----------------------------------------
    pssc_flags_t flags_ff; // Sticky fault flags
    pssc_flags_t nxt_flags; // Next flags
    wire is_bcast; // Broadcast selector
    wire pssc_flags_t sel_mask; // Selected phase mask
    // One-hot mask of a phase number, zero beyond phase 3
    function automatic pssc_flags_t phase_bit(input logic [7:0] sel);
        phase_bit = (sel < 8'h04) ? pssc_flags_t'(4'h1 << sel[1:0])
                                  : 4'h0;
    endfunction
    // Per phase: a new fault wins over a clear; unused phases stay 0
    genvar gi;
    generate
        for (gi = 0; gi < 4; gi = gi + 1) begin : g_flag
            assign nxt_flags[gi] = phase_used[gi] & (phase_fault[gi] |
                (flags_ff[gi] & ~cfg.clr_mask[gi]));
        end
    endgenerate
    // Flag register
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            flags_ff <= 4'h0;
        end else begin
            flags_ff <= nxt_flags;
        end
    end
    // ----------------------------------------
    // Read word
    // ----------------------------------------
    assign is_bcast = (cfg.phase_sel == `PSSC_PHASE_ALL) ||
                      (cfg.phase_sel == `PSSC_PHASE_ALT);
    assign sel_mask = is_bcast ? 4'hF : phase_bit(cfg.phase_sel);
    // Reserved bits 15:4 always zero
    assign cfg.sum_word = {`PSSC_FLAG_PAD, flags_ff & sel_mask};
    // ----------------------------------------
    // Checks
    // ----------------------------------------
    unused_phase_zero_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
        (flags_ff & ~phase_used) == 4'h0 || $changed(phase_used))
        else $error("unused phase flag set");
    fault_sets_flag_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
        (phase_fault[0] && phase_used[0]) |=> flags_ff[0])
        else $error("phase fault not latched");
endmodule

// File: rtl/pssc_sync_ctrl.sv
// Sync direction, presence, follower fault and oscillator fallback
`timescale 1ns/1ps
`include "pssc_params.svh"
module pssc_sync_ctrl (
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire logic sync_pin,
    input wire logic sync_pin_high,
    input wire logic sync_pin_low,
    input wire logic osc_qtick,
    input wire logic at_lower_limit,
    pssc_cfg_if.sync cfg,
    output logic sync_in_en,
    output logic sync_out_en,
    output logic sync_lock,
    output logic sync_fault,
    output logic osc_low70
);
    import pssc_pkg::*;
    // ----------------------------------------
    // Edge and presence detection
    // ----------------------------------------
    logic pin_ff; // Last pin level
    logic [2:0] gap_ff; // Quarter periods since the last edge
    logic [2:0] nxt_gap;
    wire rise_w = sync_pin & ~pin_ff;
    wire fall_w = ~sync_pin & pin_ff;
    wire edge_w = cfg.sync_edge ? rise_w : fall_w;
    wire present_w = (gap_ff <= `PSSC_GAP_MAX); // Faster than 75 % fsw
    assign nxt_gap = edge_w ? `PSSC_GAP_ZERO :
        (osc_qtick && gap_ff != `PSSC_GAP_SAT) ? gap_ff + `PSSC_GAP_ONE
                                                : gap_ff;
    // Pin history and gap counter
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            pin_ff <= 1'b0;
            gap_ff <= `PSSC_GAP_SAT;
        end else begin
            pin_ff <= sync_pin;
            gap_ff <= nxt_gap;
        end
    end
    // ----------------------------------------
    // Direction resolution
    // ----------------------------------------
    logic en_ff; // Last enable level
    logic auto_in_ff; // Auto mode chose input
    logic was_in_ff; // Effective direction was input
    logic fault_ff; // Follower sync fault
    pssc_osc_e osc_ff; // Oscillator state
    pssc_osc_e nxt_osc;
    pssc_dir_e eff_dir;
    wire en_rise = cfg.conv_en & ~en_ff;
    wire auto_pick_in = sync_pin_high | present_w;
    assign eff_dir = cfg.is_follower ? PSSC_DIR_IN :
        (cfg.sync_dir == PSSC_DIR_AUTO) ?
            (auto_in_ff ? PSSC_DIR_IN : PSSC_DIR_OUT) : cfg.sync_dir;
    wire in_to_out = was_in_ff && eff_dir == PSSC_DIR_OUT;
    // Follower fault sets only while enabled; a disable always clears it
    wire fault_set = cfg.is_follower & cfg.conv_en & ~present_w;
    // Auto pick, history and fault flag
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            en_ff <= 1'b0;
            auto_in_ff <= 1'b0;
            was_in_ff <= 1'b0;
            fault_ff <= 1'b0;
        end else begin
            en_ff <= cfg.conv_en;
            // Low and static pin, or undecided, falls back to output
            if (en_rise) begin
                auto_in_ff <= auto_pick_in & ~(sync_pin_low & ~present_w);
            end
            was_in_ff <= (eff_dir == PSSC_DIR_IN);
            fault_ff <= fault_set | (fault_ff & cfg.conv_en);
        end
    end
    // ----------------------------------------
    // Oscillator fallback
    // ----------------------------------------
    always_comb begin
        nxt_osc = osc_ff;
        case (osc_ff)
            PSSC_OSC_IDLE: begin
                if (cfg.conv_en) begin
                    nxt_osc = PSSC_OSC_RUN;
                end
            end
            PSSC_OSC_RUN: begin
                if (!cfg.conv_en) begin
                    nxt_osc = PSSC_OSC_IDLE;
                end else if (in_to_out && (at_lower_limit || fault_ff)) begin
                    nxt_osc = PSSC_OSC_HOLD;
                end
            end
            PSSC_OSC_HOLD: begin
                // Only a disable releases the 70 % frequency
                if (!cfg.conv_en) begin
                    nxt_osc = PSSC_OSC_IDLE;
                end
            end
            default: begin
                nxt_osc = PSSC_OSC_IDLE;
            end
        endcase
    end
    // State register
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            osc_ff <= PSSC_OSC_IDLE;
        end else begin
            osc_ff <= nxt_osc;
        end
    end
    assign sync_in_en = (eff_dir == PSSC_DIR_IN);
    assign sync_out_en = (eff_dir == PSSC_DIR_OUT);
    assign sync_lock = edge_w & sync_in_en;
    assign sync_fault = fault_ff;
    assign osc_low70 = (osc_ff == PSSC_OSC_HOLD);
    // ----------------------------------------
    // Checks
    // ----------------------------------------
    sequence s_drop_out;
        cfg.conv_en && in_to_out && at_lower_limit && osc_ff == PSSC_OSC_RUN;
    endsequence
    hold_low70_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
        s_drop_out |=> osc_low70)
        else $error("lower limit not held");
    low70_stay_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
        (osc_low70 && cfg.conv_en) |=> osc_low70)
        else $error("fallback dropped while enabled");
    follower_in_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
        cfg.is_follower |-> sync_in_en && !sync_out_en)
        else $error("follower not on sync input");
    follower_fault_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
        (cfg.is_follower && cfg.conv_en && gap_ff == `PSSC_GAP_SAT)
        |=> sync_fault)
        else $error("missing sync fault");
    edge_pick_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
        (cfg.sync_edge && $fell(sync_pin)) |-> !edge_w)
        else $error("wrong sync edge used");
endmodule

// File: rtl/pssc_top.sv
// Phase fault summary, sync and stack configuration command logic
`timescale 1ns/1ps
`include "pssc_params.svh"
module pssc_top (
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire logic cmd_valid,
    input wire logic cmd_write,
    input wire logic [7:0] cmd_code,
    input wire logic [15:0] cmd_wdata,
    input wire logic [7:0] phase_sel,
    input wire pssc_pkg::pssc_flags_t phase_used,
    input wire pssc_pkg::pssc_flags_t phase_fault,
    input wire logic conv_en,
    input wire logic is_follower,
    input wire logic sync_pin,
    input wire logic sync_pin_high,
    input wire logic sync_pin_low,
    input wire logic osc_qtick,
    input wire logic at_lower_limit,
    input wire logic [7:0] nvm_sync_cfg,
    input wire logic [3:0] nvm_stack_size,
    output logic rsp_valid,
    output logic [15:0] rsp_rdata,
    output logic cml_invalid_data,
    output logic cml_invalid_cmd,
    output logic cml_unsupported,
    output logic sync_in_en,
    output logic sync_out_en,
    output logic sync_lock,
    output logic sync_fault,
    output logic osc_low70,
    output logic [3:0] stack_size_field,
    output logic backchannel_pins_en
);
    import pssc_pkg::*;
    // ----------------------------------------
    // Helpers
    // ----------------------------------------
    pssc_cfg_if cfg_if ();
    pssc_fault_map u_fault (
        .sys_clk(sys_clk),
        .rst_n(rst_n),
        .phase_fault(phase_fault),
        .phase_used(phase_used),
        .cfg(cfg_if.fault)
    );
    pssc_sync_ctrl u_sync (
        .sys_clk(sys_clk),
        .rst_n(rst_n),
        .sync_pin(sync_pin),
        .sync_pin_high(sync_pin_high),
        .sync_pin_low(sync_pin_low),
        .osc_qtick(osc_qtick),
        .at_lower_limit(at_lower_limit),
        .cfg(cfg_if.sync),
        .sync_in_en(sync_in_en),
        .sync_out_en(sync_out_en),
        .sync_lock(sync_lock),
        .sync_fault(sync_fault),
        .osc_low70(osc_low70)
    );
    // ----------------------------------------
    // Registers
    // ----------------------------------------
    logic [7:0] sync_cfg_ff; // Sync configuration byte
    logic [3:0] stack_ff; // Stack size code
    logic bc_en_ff; // Backchannel pins enabled since power-up
    logic rsp_valid_ff; // Read answer strobe
    logic [15:0] rdata_ff; // Read answer data
    logic inv_data_ff; // Invalid data pulse
    logic inv_cmd_ff; // Invalid command pulse
    logic unsup_ff; // Unknown code pulse
    // ----------------------------------------
    // Command decode
    // ----------------------------------------
    wire hit_sum = (cmd_code == `PSSC_CMD_PHASE_SUM);
    wire hit_sync = (cmd_code == `PSSC_CMD_SYNC_CFG);
    wire hit_stack = (cmd_code == `PSSC_CMD_STACK_CFG);
    wire hit_any = hit_sum | hit_sync | hit_stack;
    wire wr = cmd_valid & cmd_write;
    wire rd = cmd_valid & ~cmd_write;
    // Low five bits must carry the fixed pattern
    wire sync_ok = (cmd_wdata[4:0] == `PSSC_SYNC_LOW_FIX);
    // Upper byte and address field must be zero, size at most 3
    wire stack_ok = (cmd_wdata[15:4] == 12'h000) &&
                    (cmd_wdata[3:0] <= `PSSC_STACK_MAX);
    wire sync_wr = wr & hit_sync & sync_ok;
    wire stack_locked = wr & hit_stack & conv_en;
    wire stack_wr = wr & hit_stack & ~conv_en & stack_ok;
    wire bad_data = wr & ((hit_sync & ~sync_ok) |
                          (hit_stack & ~conv_en & ~stack_ok));
    // Read selection
    wire [15:0] sync_word = {`PSSC_BYTE_PAD, sync_cfg_ff};
    wire [15:0] stack_word = {`PSSC_STACK_PAD, `PSSC_BC_FIRST_ADDR,
                              stack_ff};
    wire [15:0] rd_word = hit_sum ? cfg_if.sum_word :
                          hit_sync ? sync_word :
                          hit_stack ? stack_word : 16'h0000;
    // ----------------------------------------
    // Interface drive
    // ----------------------------------------
    assign cfg_if.sync_dir = pssc_dir_e'(sync_cfg_ff[7:6]);
    assign cfg_if.sync_edge = sync_cfg_ff[5];
    assign cfg_if.conv_en = conv_en;
    assign cfg_if.is_follower = is_follower;
    assign cfg_if.phase_sel = phase_sel;
    // Write of a one clears that phase flag
    assign cfg_if.clr_mask = (wr & hit_sum) ? cmd_wdata[3:0] : 4'h0;
    // ----------------------------------------
    // Configuration storage
    // ----------------------------------------
    // Power-up loads stored values; backchannel decided once here
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            sync_cfg_ff <= {nvm_sync_cfg[7:5], `PSSC_SYNC_LOW_FIX};
            stack_ff <= (nvm_stack_size <= `PSSC_STACK_MAX) ?
                        nvm_stack_size : `PSSC_STACK_ALONE;
            bc_en_ff <= (nvm_stack_size != `PSSC_STACK_ALONE) &&
                        (nvm_stack_size <= `PSSC_STACK_MAX);
        end else begin
            if (sync_wr) begin
                sync_cfg_ff <= cmd_wdata[7:0];
            end
            if (stack_wr) begin
                stack_ff <= cmd_wdata[3:0];
            end
        end
    end
    // ----------------------------------------
    // Answers and status pulses
    // ----------------------------------------
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            rsp_valid_ff <= 1'b0;
            rdata_ff <= 16'h0000;
            inv_data_ff <= 1'b0;
            inv_cmd_ff <= 1'b0;
            unsup_ff <= 1'b0;
        end else begin
            rsp_valid_ff <= rd;
            if (rd) begin
                rdata_ff <= rd_word;
            end
            inv_data_ff <= bad_data;
            inv_cmd_ff <= stack_locked;
            unsup_ff <= cmd_valid & ~hit_any;
        end
    end
    assign rsp_valid = rsp_valid_ff;
    assign rsp_rdata = rdata_ff;
    assign cml_invalid_data = inv_data_ff;
    assign cml_invalid_cmd = inv_cmd_ff;
    assign cml_unsupported = unsup_ff;
    assign stack_size_field = stack_ff;
    assign backchannel_pins_en = bc_en_ff;
    // ----------------------------------------
    // Checks
    // ----------------------------------------
    sequence s_stack_wr_on;
        wr && hit_stack && conv_en;
    endsequence
    stack_lock_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
        s_stack_wr_on |=> $stable(stack_ff) && cml_invalid_cmd)
        else $error("stack changed while enabled");
    bad_sync_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
        (wr && hit_sync && !sync_ok) |=> cml_invalid_data &&
        $stable(sync_cfg_ff))
        else $error("invalid sync write not flagged");
    stack_read_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
        (rd && hit_stack) |=> rsp_rdata[15:4] == 12'h000)
        else $error("stack upper bits not zero");
    sum_high_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
        (rd && hit_sum) |=> rsp_valid && rsp_rdata[15:4] == 12'h000)
        else $error("summary reserved bits set");
    bc_fixed_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
        ##1 $stable(backchannel_pins_en))
        else $error("backchannel enable moved");
    stack_range_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
        stack_ff <= `PSSC_STACK_MAX)
        else $error("stack code out of range");
endmodule

// File: test/pssc_sync_src.sv
// Model of the sync source and oscillator tick beside the block
`timescale 1ns/1ps
module pssc_sync_src (
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire logic run,
    output logic sync_pin,
    output logic sync_pin_high,
    output logic sync_pin_low,
    output logic osc_qtick
);
    logic [2:0] div_ff; // Free cycle divider
    // ----------------------------------------
    // Divider
    // ----------------------------------------
    // Counts cycles, one tick every second cycle
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            div_ff <= 3'h0;
        end else begin
            div_ff <= div_ff + 3'h1;
        end
    end
    // ----------------------------------------
    // Pin levels
    // ----------------------------------------
    assign osc_qtick = div_ff[0]; // Quarter period tick
    // Toggles every two ticks while running, else static low
    assign sync_pin = run & div_ff[2];
    assign sync_pin_high = sync_pin; // Above upper threshold
    assign sync_pin_low = ~sync_pin; // Below lower threshold
endmodule

// File: test/tb_top.sv
// Self-checking bench for the phase, sync and stack command logic
`timescale 1ns/1ps
module tb_top;
    import pssc_pkg::*;
    // ----------------------------------------
    // Signals
    // ----------------------------------------
    logic sys_clk = 1'b0; // Bench clock
    logic rst_n = 1'b0; // Reset, active low
    logic cmd_valid = 1'b0;
    logic cmd_write = 1'b0;
    logic [7:0] cmd_code = 8'h00;
    logic [15:0] cmd_wdata = 16'h0000;
    logic [7:0] phase_sel = 8'hFF;
    pssc_flags_t phase_used = 4'hF;
    pssc_flags_t phase_fault = 4'h0;
    logic conv_en = 1'b0;
    logic is_follower = 1'b0;
    logic at_lower_limit = 1'b0;
    logic run = 1'b0; // Sync source active
    logic [7:0] nvm_sync_cfg = 8'h50;
    logic [3:0] nvm_stack_size = 4'h2; // Stored: three phases
    logic sync_pin, sync_pin_high, sync_pin_low, osc_qtick;
    logic rsp_valid, cml_invalid_data, cml_invalid_cmd, cml_unsupported;
    logic [15:0] rsp_rdata;
    logic sync_in_en, sync_out_en, sync_lock, sync_fault, osc_low70;
    logic [3:0] stack_size_field;
    logic backchannel_pins_en;
    wire logic [4:0] watch = {sync_lock, osc_low70, sync_out_en,
                              sync_in_en, sync_fault};
    logic [18:0] exp_q[$]; // Expected {flags, read word}
    int n_fail = 0;
    int checks_done = 0;
    int seed = 24248;
    logic [15:0] rnd;
    logic [7:0] sels [6] = '{8'hFF, 8'h80, 8'h00, 8'h01, 8'h02, 8'h03};
    // ----------------------------------------
    // Instances
    // ----------------------------------------
    pssc_top DUT (.sys_clk(sys_clk), .rst_n(rst_n), .cmd_valid(cmd_valid),
        .cmd_write(cmd_write), .cmd_code(cmd_code), .cmd_wdata(cmd_wdata),
        .phase_sel(phase_sel), .phase_used(phase_used),
        .phase_fault(phase_fault), .conv_en(conv_en),
        .is_follower(is_follower), .sync_pin(sync_pin),
        .sync_pin_high(sync_pin_high), .sync_pin_low(sync_pin_low),
        .osc_qtick(osc_qtick), .at_lower_limit(at_lower_limit),
        .nvm_sync_cfg(nvm_sync_cfg), .nvm_stack_size(nvm_stack_size),
        .rsp_valid(rsp_valid), .rsp_rdata(rsp_rdata),
        .cml_invalid_data(cml_invalid_data),
        .cml_invalid_cmd(cml_invalid_cmd),
        .cml_unsupported(cml_unsupported), .sync_in_en(sync_in_en),
        .sync_out_en(sync_out_en), .sync_lock(sync_lock),
        .sync_fault(sync_fault), .osc_low70(osc_low70),
        .stack_size_field(stack_size_field),
        .backchannel_pins_en(backchannel_pins_en));
    pssc_sync_src peer (.sys_clk(sys_clk), .rst_n(rst_n), .run(run),
        .sync_pin(sync_pin), .sync_pin_high(sync_pin_high),
        .sync_pin_low(sync_pin_low), .osc_qtick(osc_qtick));
    // Clock, 50 ns period
    initial begin
        forever #25 sys_clk = ~sys_clk;
    end
    // ----------------------------------------
    // Tasks
    // ----------------------------------------
    // Compares and counts
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            n_fail++;
            $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    // Prints the counts and the verdict, then stops
    task automatic tally_and_finish();
        $display("checks_done=%0d n_fail=%0d", checks_done, n_fail);
        if (n_fail == 0 && checks_done > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask
    // One command strobe; notes the expected result if one comes
    task automatic cmd(input logic wr, input logic [7:0] code,
                       input logic [15:0] data, input logic [18:0] exp,
                       input bit note);
        @(posedge sys_clk);
        #1;
        cmd_valid = 1'b1;
        cmd_write = wr;
        cmd_code = code;
        cmd_wdata = data;
        if (note) begin
            exp_q.push_back(exp);
        end
        @(posedge sys_clk);
        #1;
        cmd_valid = 1'b0;
    endtask
    task automatic rd(input logic [7:0] code, input logic [15:0] exp);
        cmd(1'b0, code, 16'h0000, {3'h0, exp}, 1'b1);
    endtask
    task automatic wr_ok(input logic [7:0] code, input logic [15:0] data);
        cmd(1'b1, code, data, 19'h00000, 1'b0);
    endtask
    // Write expected to raise {invalid data, invalid cmd, unsupported}
    task automatic wr_err(input logic [7:0] code, input logic [15:0] data,
                          input logic [2:0] flags);
        cmd(1'b1, code, data, {flags, 16'h0000}, 1'b1);
    endtask
    // Bounded wait for one watched output to reach a level
    task automatic wait_bit(input int b, input logic v);
        int i;
        for (i = 0; i < 60; i++) begin
            @(posedge sys_clk);
            #1;
            if (watch[b] === v) break;
        end
        check(watch[b], v);
        if (i == 60) begin
            tally_and_finish();
        end
    endtask
    // ----------------------------------------
    // Result monitor
    // ----------------------------------------
    // Takes the oldest note whenever a response or error pulse shows
    always @(posedge sys_clk) begin
        if (rst_n && (rsp_valid || cml_invalid_data || cml_invalid_cmd ||
                      cml_unsupported)) begin
            if (exp_q.size() == 0) begin
                check(32'h1, 32'h0);
            end else begin
                check({cml_invalid_data, cml_invalid_cmd, cml_unsupported,
                       rsp_valid ? rsp_rdata : 16'h0000},
                      exp_q.pop_front());
            end
        end
    end
    // ----------------------------------------
    // Main sequence
    // ----------------------------------------
    initial begin
        repeat (10) @(posedge sys_clk);
        #1;
        rst_n = 1'b1;
        rd(8'hE4, 16'h0050);
        rd(8'hEC, 16'h0002);
        check(backchannel_pins_en, 1'b1);
        // Every direction and edge, low bits kept at the fixed pattern
        for (int d = 0; d < 8; d++) begin
            wr_ok(8'hE4, {8'h00, d[2:0], 5'h10});
            rd(8'hE4, {8'h00, d[2:0], 5'h10});
            if (d[2:1] != 2'h3) begin
                check({sync_in_en, sync_out_en},
                      {d[2:1] == 2'h2, d[2:1] == 2'h1});
            end
        end
        // Bad low bits refused, value kept
        rnd = $random(seed);
        rnd[4:0] = (rnd[4:0] == 5'h10) ? 5'h11 : rnd[4:0];
        wr_err(8'hE4, {8'h00, rnd[7:0]}, 3'h4);
        rd(8'hE4, 16'h00F0);
        // Valid stack codes, live after a multiphase power-up
        for (int s = 0; s < 4; s++) begin
            wr_ok(8'hEC, {12'h000, s[3:0]});
            check(stack_size_field, s[3:0]);
            rd(8'hEC, {12'h000, s[3:0]});
        end
        check(backchannel_pins_en, 1'b1);
        for (int s = 4; s < 16; s++) begin
            wr_err(8'hEC, {12'h000, s[3:0]}, 3'h4);
        end
        rnd = $random(seed);
        wr_err(8'hEC, {rnd[11:0] | 12'h001, 4'h1}, 3'h4);
        conv_en = 1'b1;
        wr_err(8'hEC, 16'h0001, 3'h2);
        conv_en = 1'b0;
        rd(8'hEC, 16'h0003);
        wr_err(8'hA0, 16'h0000, 3'h1);
        // Fault summary under both broadcast selectors and each single phase selector 0 to 3
        phase_used = 4'hB;
        rnd = $random(seed);
        phase_fault = 4'hF;
        repeat (2) @(posedge sys_clk);
        #1;
        phase_fault = rnd[3:0] & 4'h4; // Unused phase only
        for (int i = 0; i < 6; i++) begin
            phase_sel = sels[i];
            rd(8'hDC, {12'h000, i < 2 ? 4'hB
                       : 4'hB & (4'h1 << (i - 2))});
        end
        phase_fault = 4'h0;
        phase_sel = 8'hFF;
        wr_ok(8'hDC, 16'h000F);
        rd(8'hDC, 16'h0000);
        // Follower enabled with no sync present
        is_follower = 1'b1;
        conv_en = 1'b1;
        wait_bit(0, 1'b1);
        conv_en = 1'b0;
        wait_bit(0, 1'b0);
        is_follower = 1'b0;
        // Auto mode: toggling pin then static low pin
        run = 1'b1;
        repeat (20) @(posedge sys_clk);
        #1;
        conv_en = 1'b1;
        wait_bit(1, 1'b1);
        wait_bit(4, 1'b1);
        conv_en = 1'b0;
        run = 1'b0;
        repeat (20) @(posedge sys_clk);
        #1;
        conv_en = 1'b1;
        wait_bit(2, 1'b1);
        conv_en = 1'b0;
        // Input to output at the lower limit while enabled
        wr_ok(8'hE4, 16'h0090);
        run = 1'b1;
        at_lower_limit = 1'b1;
        conv_en = 1'b1;
        repeat (20) @(posedge sys_clk);
        wr_ok(8'hE4, 16'h0050);
        wait_bit(3, 1'b1);
        conv_en = 1'b0;
        wait_bit(3, 1'b0);
        at_lower_limit = 1'b0;
        run = 1'b0;
        // Second power-up standalone keeps the backchannel off
        rst_n = 1'b0;
        nvm_stack_size = 4'h0;
        repeat (10) @(posedge sys_clk);
        #1;
        rst_n = 1'b1;
        check(backchannel_pins_en, 1'b0);
        wr_ok(8'hEC, 16'h0003);
        check(stack_size_field, 4'h3);
        check(backchannel_pins_en, 1'b0);
        rst_n = 1'b0;
        nvm_stack_size = 4'h3;
        repeat (10) @(posedge sys_clk);
        #1;
        rst_n = 1'b1;
        check(backchannel_pins_en, 1'b1);
        repeat (4) @(posedge sys_clk);
        check(exp_q.size(), 0);
        tally_and_finish();
    end
endmodule
